// ===== rtl/reset_boot_memory_map.v
// reset sequencing, boot straps and address decode of the microcontroller
//
// Overview of operation
// - mux pins come up as inputs after reset
// - clock out low in reset, then toggles at half the clock rate
// - reset clears peripheral registers, fetches from zero
// - external reset enters asynchronously, watchdog through two flops; exit synchronised to clock
// - first fetch eighty cycles after reset release
// - watchdog reset keeps latched strap modes
// - external reset wins over watchdog reset
// - float mode disables the clock out driver and holds chip selects high
// - float strap low last ten cycles enters float
// - low 4MB internal, high 4MB peripherals, rest external
// - little-endian byte lanes only
// - internal memory 32-bit, single-cycle byte/half/word
// - after remap SRAM sits at address zero
// - boot strap one 8-bit, zero 16-bit
// - remap bit puts SRAM in place of boot memory in the low region
// - chip selects 1..7 only after remap
// - remap persists until any reset
// - undefined external address aborts; internal never
// - byte/half/word external; 8x1M to 4x16M banks
// - per-bank waits, float, width, modes, early read
`timescale 1ns/1ns
`include "reset_boot_map.vh"

module reset_boot_memory_map (
  input  wire        clock,
  input  wire        srst,
  input  wire        external_reset_n,
  input  wire        watchdog_reset,
  input  wire        output_float_strap_n,
  input  wire        boot_width_strap,
  input  wire        remap_command_bit,
  input  wire        bank_layout,
  input  wire [2:0]  bank_wait_cfg,
  input  wire [2:0]  bank_float_cfg,
  input  wire        bank_width16_cfg,
  input  wire        bank_byte_write_cfg,
  input  wire        bank_early_read_cfg,
  input  wire        cpu_req,
  input  wire        cpu_write,
  input  wire        cpu_fetch,
  input  wire [1:0]  cpu_size,
  input  wire [31:0] cpu_addr,
  input  wire [31:0] cpu_wdata,
  output reg         core_reset_q,
  output reg         periph_reset_q,
  output reg         fetch_start_q,
  output reg  [31:0] fetch_addr_q,
  output reg         clock_out_pin,
  output reg         clock_out_oe_n_q,
  output reg         outputs_float_q,
  output reg         boot_8bit_q,
  output reg         remapped_q,
  output reg  [`RBM_PIO_W-1:0] pio_dir_out_q,
  output reg  [2:0]  region_q,
  output reg  [7:0]  ext_cs_n_q,
  output reg  [2:0]  ext_wait_q,
  output reg  [2:0]  ext_float_q,
  output reg         ext_width16_q,
  output reg         ext_byte_write_q,
  output reg         ext_early_read_q,
  output reg  [3:0]  ext_byte_en_q,
  output reg         cpu_abort_q,
  output reg         cpu_ready_q,
  output reg  [31:0] cpu_rdata_q
);

  ////////////////////////////////////////////////////////////////////////////
  // reset capture and release synchroniser

  reg                  ext_meta_q;
  reg                  ext_sync_q;
  reg                  wd_meta_q;
  reg                  wd_sync_q;
  reg                  float_meta_q;
  reg                  float_sync_q;
  reg                  boot_meta_q;
  reg                  boot_sync_q;
  reg                  ext_held_q;
  reg                  in_reset_q;
  reg [`RBM_CNT_W-1:0] fetch_cnt_q;
  wire                 float_all_low;
  wire                 boot_last;
  wire                 release_edge;

  // reset entry is taken from the raw pin level, release waits two flops
  always @(posedge clock or negedge external_reset_n) begin
    if (!external_reset_n) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= 1'b1;
      ext_sync_q <= ext_meta_q;
    end
  end

  // watchdog request and strap pins pass two flops
  always @(posedge clock) begin
    if (srst) begin
      wd_meta_q    <= 1'b0;
      wd_sync_q    <= 1'b0;
      float_meta_q <= 1'b1;
      float_sync_q <= 1'b1;
      boot_meta_q  <= 1'b0;
      boot_sync_q  <= 1'b0;
    end else begin
      wd_meta_q    <= watchdog_reset;
      wd_sync_q    <= wd_meta_q;
      float_meta_q <= output_float_strap_n;
      float_sync_q <= float_meta_q;
      boot_meta_q  <= boot_width_strap;
      boot_sync_q  <= boot_meta_q;
    end
  end

  assign release_edge = ext_held_q & ext_sync_q;

  // reset state, external source tracked apart from the watchdog
  always @(posedge clock) begin
    if (srst) begin
      ext_held_q <= 1'b1;
      in_reset_q <= 1'b1;
    end else begin
      ext_held_q <= ~ext_sync_q;
      in_reset_q <= ~ext_sync_q | wd_sync_q;
    end
  end

  // strap windows see only the external reset period
  strap_window u_float_win (
    .clock     (clock),
    .in_reset  (ext_held_q),
    .strap     (float_sync_q),
    .all_low_q (float_all_low),
    .last_q    ()
  );

  strap_window u_boot_win (
    .clock     (clock),
    .in_reset  (ext_held_q),
    .strap     (~boot_sync_q),
    .all_low_q (),
    .last_q    (boot_last)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap latching, fetch counter and reset outputs

  // straps latched only on external release; watchdog leaves them alone
  always @(posedge clock) begin
    if (srst) begin
      outputs_float_q <= 1'b0;
      boot_8bit_q     <= `RBM_BOOT_8BIT;
    end else if (release_edge) begin
      outputs_float_q <= float_all_low;
      boot_8bit_q     <= boot_last ? `RBM_BOOT_16BIT : `RBM_BOOT_8BIT;
    end
  end

  // count to the first instruction fetch after release
  always @(posedge clock) begin
    if (srst) begin
      fetch_cnt_q    <= 8'h00;
      core_reset_q   <= 1'b1;
      periph_reset_q <= 1'b1;
      fetch_start_q  <= 1'b0;
      fetch_addr_q   <= 32'h0000_0000;
    end else if (in_reset_q) begin
      fetch_cnt_q    <= 8'h00;
      core_reset_q   <= 1'b1;
      periph_reset_q <= 1'b1;
      fetch_start_q  <= 1'b0;
      fetch_addr_q   <= 32'h0000_0000;
    end else if (core_reset_q) begin
      periph_reset_q <= 1'b0;
      fetch_cnt_q    <= fetch_cnt_q + 8'h01;
      if (fetch_cnt_q == (`RBM_FETCH_DELAY - 8'h03)) begin
        core_reset_q  <= 1'b0;
        fetch_start_q <= 1'b1;
      end
    end else begin
      fetch_start_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: clock copy, float and pio direction

  // half-rate clock out gated low in reset, drivers off in float mode
  always @(posedge clock) begin
    if (srst || in_reset_q) begin
      clock_out_pin    <= 1'b0;
      clock_out_oe_n_q <= srst ? 1'b0 : outputs_float_q;
      pio_dir_out_q    <= 32'h0000_0000;
    end else begin
      clock_out_pin    <= ~clock_out_pin;
      clock_out_oe_n_q <= outputs_float_q;
      pio_dir_out_q    <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remap state

  always @(posedge clock) begin
    if (srst || in_reset_q)
      remapped_q <= 1'b0;
    else if (remap_command_bit)
      remapped_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // bank number of an external address for the selected layout
  function [2:0] ext_bank;
    input [31:0] a;
    input        layout;
    begin
      if (layout == `RBM_LAYOUT_4X16M)
        ext_bank = {1'b0, a[25:24]};
      else
        ext_bank = a[22:20];
    end
  endfunction

  // whether an external address falls inside a defined bank
  function ext_defined;
    input [31:0] a;
    input        layout;
    begin
      if (layout == `RBM_LAYOUT_4X16M)
        ext_defined = (a[31:26] == 6'h00);
      else
        ext_defined = (a[31:23] == 9'h000);
    end
  endfunction

  // little-endian lane enables from size and low address bits
  function [3:0] lanes;
    input [1:0] size;
    input [1:0] a;
    begin
      case (size)
        2'h0:    lanes = 4'h1 << a;
        2'h1:    lanes = a[1] ? 4'hc : 4'h3;
        default: lanes = 4'hf;
      endcase
    end
  endfunction

  reg [2:0] region_d;
  reg [2:0] bank_d;
  reg       abort_d;
  reg [7:0] cs_n_d;

  // region and chip select for the current request
  always @* begin
    region_d = `RBM_RGN_UNDEF;
    bank_d   = 3'h0;
    abort_d  = 1'b0;
    cs_n_d   = 8'hff;
    if (cpu_addr < `RBM_INT_MEM_TOP) begin
      if (remapped_q)
        region_d = `RBM_RGN_SRAM;
      else begin
        region_d = `RBM_RGN_BOOT;
        cs_n_d   = 8'hfe;
      end
    end else if (cpu_addr >= `RBM_PERIPH_BASE) begin
      region_d = `RBM_RGN_PERIPH;
    end else if (ext_defined(cpu_addr, bank_layout)) begin
      bank_d = ext_bank(cpu_addr, bank_layout);
      if (bank_d != 3'h0 && !remapped_q) begin
        abort_d = 1'b1;
      end else begin
        region_d = `RBM_RGN_EXT;
        cs_n_d   = ~(8'h01 << bank_d);
      end
    end else begin
      abort_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal SRAM, single cycle byte/half/word

  wire [9:0]  sram_idx;
  wire [3:0]  lane_en;
  wire        sram_hit;
  wire [31:0] sram_rd;

  assign sram_idx = cpu_addr[11:2];
  assign lane_en  = lanes(cpu_size, cpu_addr[1:0]);
  assign sram_hit = cpu_req & (region_d == `RBM_RGN_SRAM);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      // one byte array per lane, so each array has a single writer
      reg [7:0] lane_mem [0:1023];
      always @(posedge clock) begin
        if (sram_hit && cpu_write && lane_en[gi])
          lane_mem[sram_idx] <= cpu_wdata[gi*8 +: 8];
      end
      assign sram_rd[gi*8 +: 8] = lane_mem[sram_idx];
    end
  endgenerate

  // registered answer; internal accesses finish in one cycle
  always @(posedge clock) begin
    if (srst || in_reset_q) begin
      region_q         <= `RBM_RGN_UNDEF;
      ext_cs_n_q       <= 8'hff;
      cpu_abort_q      <= 1'b0;
      cpu_ready_q      <= 1'b0;
      cpu_rdata_q      <= 32'h0000_0000;
      ext_byte_en_q    <= 4'h0;
      ext_wait_q       <= `RBM_WAIT_RST;
      ext_float_q      <= `RBM_FLOAT_RST;
      ext_width16_q    <= 1'b0;
      ext_byte_write_q <= 1'b0;
      ext_early_read_q <= 1'b0;
    end else begin
      region_q         <= region_d;
      ext_cs_n_q       <= (cpu_req && !outputs_float_q) ? cs_n_d : 8'hff;
      cpu_abort_q      <= cpu_req & abort_d;
      cpu_ready_q      <= cpu_req;
      ext_byte_en_q    <= cpu_req ? lane_en : 4'h0;
      ext_wait_q       <= bank_wait_cfg;
      ext_float_q      <= bank_float_cfg;
      ext_width16_q    <= (region_d == `RBM_RGN_BOOT) ? ~boot_8bit_q : bank_width16_cfg;
      ext_byte_write_q <= bank_byte_write_cfg;
      ext_early_read_q <= bank_early_read_cfg;
      if (sram_hit && !cpu_write)
        cpu_rdata_q <= sram_rd;
      else
        cpu_rdata_q <= 32'h0000_0000;
    end
  end

endmodule

// ===== rtl/reset_boot_map.vh
// constants for the reset, boot strap and address map block
`ifndef RESET_BOOT_MAP_VH
`define RESET_BOOT_MAP_VH

// timing counts in master clock cycles
`define RBM_STRAP_WINDOW     8'd10
`define RBM_FETCH_DELAY      8'd80
`define RBM_CNT_W            8

// address regions (full 32-bit byte addresses)
`define RBM_INT_MEM_TOP      32'h0040_0000
`define RBM_PERIPH_BASE      32'hffc0_0000
`define RBM_VECTOR_END       32'h0000_0020

// region codes
`define RBM_RGN_SRAM         3'h0
`define RBM_RGN_BOOT         3'h1
`define RBM_RGN_EXT          3'h2
`define RBM_RGN_PERIPH       3'h3
`define RBM_RGN_UNDEF        3'h4

// boot strap encoding
`define RBM_BOOT_8BIT        1'b1
`define RBM_BOOT_16BIT       1'b0

// external bank layout codes
`define RBM_LAYOUT_8X1M      1'b0
`define RBM_LAYOUT_4X16M     1'b1

// reset values and sizes
`define RBM_WAIT_RST         3'h0
`define RBM_FLOAT_RST        3'h0
`define RBM_BANKS            8
`define RBM_PIO_W            32

`endif

// ===== rtl/strap_window.v
// low-throughout filter over the last cycles before reset release
`timescale 1ns/1ns
`include "reset_boot_map.vh"

module strap_window (
  input  wire       clock,
  input  wire       in_reset,
  input  wire       strap,
  output reg        all_low_q,
  output reg        last_q
);

  reg [`RBM_CNT_W-1:0] low_run_q;

  // count consecutive low samples while reset is held, saturating at the window
  always @(posedge clock) begin
    if (!in_reset) begin
      low_run_q <= low_run_q;
      last_q    <= last_q;
      all_low_q <= all_low_q;
    end else if (strap) begin
      low_run_q <= 8'h00;
      last_q    <= 1'b1;
      all_low_q <= 1'b0;
    end else begin
      if (low_run_q < `RBM_STRAP_WINDOW)
        low_run_q <= low_run_q + 8'h01;
      last_q    <= 1'b0;
      all_low_q <= (low_run_q >= (`RBM_STRAP_WINDOW - 8'h01));
    end
  end

endmodule

// ===== testbench/reset_pin_model.sv
// reset source and strap resistor model at the pins
`timescale 1ns/1ns

module reset_pin_model (
  input  wire       clock,
  input  wire       hold_req,
  input  wire       float_req,
  input  wire       boot8_req,
  output reg        external_reset_n,
  output reg        output_float_strap_n,
  output reg        boot_width_strap
);
  reg [3:0] low_cnt_q;

  initial begin
    external_reset_n = 1'b0;
    output_float_strap_n = 1'b1;
    boot_width_strap = 1'b1;
    low_cnt_q = 4'h0;
  end

  ////////////////////////////////////////////////////////////
  // pin stays low twelve running clocks after hold drops
  always @(posedge clock) begin
    if (hold_req) begin
      external_reset_n <= 1'b0;
      low_cnt_q <= 4'h0;
    end else if (!external_reset_n && low_cnt_q != 4'hc) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end else begin
      external_reset_n <= 1'b1;
    end
  end

  // straps steady in reset; then pull-up or a toggling line
  always @(posedge clock) begin
    if (!external_reset_n || hold_req) begin
      output_float_strap_n <= !float_req;
      boot_width_strap <= boot8_req;
    end else begin
      output_float_strap_n <= 1'b1;
      boot_width_strap <= !boot_width_strap;
    end
  end
endmodule

// ===== testbench/reset_boot_monitor.sv
// assertions on reset sequencing and address decode
`timescale 1ns/1ns
`include "reset_boot_map.vh"

module reset_boot_monitor (
  input wire                  clock,
  input wire                  srst,
  input wire                  external_reset_n,
  input wire                  watchdog_reset,
  input wire                  cpu_req,
  input wire                  core_reset_q,
  input wire                  fetch_start_q,
  input wire [31:0]           fetch_addr_q,
  input wire                  clock_out_pin,
  input wire                  clock_out_oe_n_q,
  input wire                  outputs_float_q,
  input wire                  remapped_q,
  input wire [`RBM_PIO_W-1:0] pio_dir_out_q,
  input wire [2:0]            region_q,
  input wire [7:0]            ext_cs_n_q,
  input wire                  cpu_abort_q,
  input wire                  cpu_ready_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // release edge, then the first fetch
  sequence seq_release;
    $rose(external_reset_n);
  endsequence
  sequence seq_first_fetch;
    ##[78:82] fetch_start_q;
  endsequence

  chk_fetch_delay: assert property (seq_release |-> seq_first_fetch)
    else $error("first fetch out of time");
  chk_fetch_zero: assert property (fetch_start_q |-> fetch_addr_q == 32'h0)
    else $error("first fetch not at zero");
  chk_clock_low: assert property ((!external_reset_n) [*3] |-> !clock_out_pin)
    else $error("clock out not low in reset");
  chk_reset_entry: assert property ($fell(external_reset_n) |-> ##[0:3] core_reset_q)
    else $error("reset not entered");
  chk_pio_input: assert property (core_reset_q |=> pio_dir_out_q == 0)
    else $error("pin not input after reset");
  chk_float_oe: assert property (outputs_float_q |=> clock_out_oe_n_q)
    else $error("driver on in float mode");
  chk_ready_lat: assert property (cpu_req && !core_reset_q && $past(!core_reset_q) |=> cpu_ready_q)
    else $error("no single cycle answer");
  chk_internal_noabort: assert property (cpu_ready_q && (region_q == `RBM_RGN_SRAM
    || region_q == `RBM_RGN_PERIPH) |-> !cpu_abort_q)
    else $error("internal access aborted");
  chk_cs_remap: assert property (cpu_ready_q && !remapped_q |-> &ext_cs_n_q[7:1])
    else $error("upper select before remap");
  chk_remap_stays: assert property (remapped_q && external_reset_n && !watchdog_reset
    && !core_reset_q |=> remapped_q)
    else $error("remap lost without reset");
endmodule

bind reset_boot_memory_map reset_boot_monitor u_mon (.clock, .srst, .external_reset_n, .watchdog_reset,
  .cpu_req, .core_reset_q, .fetch_start_q, .fetch_addr_q, .clock_out_pin, .clock_out_oe_n_q,
  .outputs_float_q, .remapped_q, .pio_dir_out_q, .region_q, .ext_cs_n_q, .cpu_abort_q, .cpu_ready_q);

// ===== testbench/reset_boot_memory_map_tb.sv
// self-checking bench for reset, straps and address map
`timescale 1ns/1ns
`include "reset_boot_map.vh"

module reset_boot_memory_map_tb;
  typedef struct packed {
    logic lay; logic rmp; logic [31:0] a; logic [1:0] sz; logic [2:0] rg; logic ab; logic [3:0] be;
  } row_t;
  logic        clock, srst, hold_req, float_req, boot8_req, watchdog_reset, remap_command_bit;
  logic        bank_layout, cpu_req, cpu_write, cpu_fetch, c0;
  logic [1:0]  cpu_size;
  logic [31:0] cpu_addr, cpu_wdata;
  wire         external_reset_n, output_float_strap_n, boot_width_strap, core_reset_q, fetch_start_q;
  wire         clock_out_pin, clock_out_oe_n_q, outputs_float_q, boot_8bit_q, remapped_q;
  wire         ext_width16_q, ext_byte_write_q, ext_early_read_q, cpu_abort_q, cpu_ready_q, periph_reset_q;
  wire [7:0]   ext_cs_n_q;
  wire [31:0]  fetch_addr_q, pio_dir_out_q, cpu_rdata_q;
  wire [2:0]   region_q, ext_wait_q, ext_float_q;
  wire [3:0]   ext_byte_en_q;
  int          errors, cmp_count, i;
  row_t        rows [11];

  reset_pin_model pins (.clock, .hold_req, .float_req, .boot8_req, .external_reset_n,
    .output_float_strap_n, .boot_width_strap);

  reset_boot_memory_map dut (.clock, .srst, .external_reset_n, .watchdog_reset, .output_float_strap_n,
    .boot_width_strap, .remap_command_bit, .bank_layout, .bank_wait_cfg(3'h5), .bank_float_cfg(3'h2),
    .bank_width16_cfg(1'b1), .bank_byte_write_cfg(1'b1), .bank_early_read_cfg(1'b1), .cpu_req,
    .cpu_write, .cpu_fetch, .cpu_size, .cpu_addr, .cpu_wdata, .core_reset_q, .periph_reset_q,
    .fetch_start_q, .fetch_addr_q, .clock_out_pin, .clock_out_oe_n_q, .outputs_float_q, .boot_8bit_q,
    .remapped_q, .pio_dir_out_q, .region_q, .ext_cs_n_q, .ext_wait_q, .ext_float_q, .ext_width16_q,
    .ext_byte_write_q, .ext_early_read_q, .ext_byte_en_q, .cpu_abort_q, .cpu_ready_q, .cpu_rdata_q);

  ////////////////////////////////////////////////////////////
  // clock and shared tasks
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_value(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait on one of the handshake signals
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    int k;
    logic v;
    for (k = 0; k <= lim; k++) begin
      v = sel == 0 ? core_reset_q : sel == 1 ? fetch_start_q : sel == 2 ? external_reset_n : cpu_ready_q;
      if (v === lvl) return;
      tick(1);
    end
    errors++;
    $display("CHECK FAILED wait %0d expected %b seen timeout", sel, lvl);
    give_verdict;
  endtask

  // one request edge; req stays up so back-to-back calls never re-assign it in one step
  task automatic access(input logic [31:0] a, input logic [1:0] sz, input logic wr, input logic [31:0] wd);
    cpu_addr = a;
    cpu_size = sz;
    cpu_write = wr;
    cpu_fetch = !wr;
    cpu_wdata = wd;
    cpu_req = 1'b1;
    tick(1);
    wait_sig(3, 1'b1, 4);
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {srst, hold_req, boot8_req} = 3'h7;
    {float_req, watchdog_reset, remap_command_bit, bank_layout, cpu_req, cpu_write, cpu_fetch} = 7'h0;
    {cpu_size, cpu_addr, cpu_wdata} = 66'h0;
    errors = 0;
    cmp_count = 0;
    rows = '{'{0, 0, 32'h0, 2, `RBM_RGN_BOOT, 0, 0}, '{0, 0, 32'h0040_0000, 2, 7, 1, 0},
      '{0, 0, 32'hffc0_0000, 2, `RBM_RGN_PERIPH, 0, 0}, '{0, 1, 32'h10, 2, `RBM_RGN_SRAM, 0, 0},
      '{0, 1, 32'h0040_0002, 0, `RBM_RGN_EXT, 0, 4'h4}, '{0, 1, 32'h0050_0002, 1, `RBM_RGN_EXT, 0, 4'hc},
      '{0, 1, 32'h0080_0000, 2, 7, 1, 0}, '{0, 1, 32'h003f_fffc, 2, 7, 0, 0},
      '{1, 1, 32'h0100_0000, 2, `RBM_RGN_EXT, 0, 4'hf}, '{1, 1, 32'h0400_0000, 2, 7, 1, 0},
      '{0, 1, 32'hffff_fffc, 2, `RBM_RGN_PERIPH, 0, 0}};
    tick(5);
    srst = 1'b0;
    hold_req = 1'b0;
    wait_sig(2, 1'b1, 40);
    wait_sig(1, 1'b1, 100);
    check_value("fetch_addr", 0, fetch_addr_q);
    check_value("pio_dir", 0, pio_dir_out_q);
    check_value("periph_rst", 0, periph_reset_q);
    check_value("boot_8bit", 1, boot_8bit_q);
    check_value("float", 0, outputs_float_q);
    c0 = clock_out_pin;
    tick(1);
    check_value("clock_out", !c0, clock_out_pin);
    $display("test release done");
    for (i = 0; i < 11; i++) begin
      if (rows[i].rmp && remapped_q !== 1'b1) begin
        remap_command_bit = 1'b1;
        tick(1);
        remap_command_bit = 1'b0;
        tick(1);
        check_value("remapped", 1, remapped_q);
      end
      bank_layout = rows[i].lay;
      access(rows[i].a, rows[i].sz, 1'b0, 32'h0);
      check_value("abort", rows[i].ab, cpu_abort_q);
      if (rows[i].rg != 3'h7) check_value("region", rows[i].rg, region_q);
      if (rows[i].rg == `RBM_RGN_BOOT) check_value("boot_cs", 32'hfe, ext_cs_n_q);
      if (rows[i].be != 4'h0) check_value("byte_en", rows[i].be, ext_byte_en_q);
    end
    access(32'h4, 2'h2, 1'b1, 32'ha1b2_c3d4);
    access(32'h5, 2'h0, 1'b1, 32'h5555_5555);
    access(32'h4, 2'h2, 1'b0, 32'h0);
    check_value("sram_rdata", 32'ha1b2_55d4, cpu_rdata_q);
    check_value("bank_cfg", 9'h157, {ext_wait_q, ext_float_q, ext_width16_q, ext_byte_write_q,
      ext_early_read_q});
    $display("test decode done");
    cpu_req = 1'b0;
    watchdog_reset = 1'b1;
    wait_sig(0, 1'b1, 6);
    check_value("wd_periph_rst", 1, periph_reset_q);
    watchdog_reset = 1'b0;
    wait_sig(0, 1'b0, 150);
    check_value("wd_remap", 0, remapped_q);
    check_value("wd_boot", 1, boot_8bit_q);
    $display("test watchdog done");
    {hold_req, watchdog_reset, float_req, boot8_req} = 4'he;
    tick(3);
    watchdog_reset = 1'b0;
    tick(3);
    hold_req = 1'b0;
    wait_sig(2, 1'b1, 40);
    wait_sig(1, 1'b1, 100);
    check_value("float", 1, outputs_float_q);
    check_value("float_oe", 1, clock_out_oe_n_q);
    check_value("boot_8bit", 0, boot_8bit_q);
    $display("test straps done");
    give_verdict;
  end
endmodule
